// ===== design/cscc_pkg.sv
package cscc_pkg;

    // apb register byte offsets
    localparam logic [7:0] CSCC_OFS_CFG    = 8'h00;
    localparam logic [7:0] CSCC_OFS_CMD    = 8'h04;
    localparam logic [7:0] CSCC_OFS_STATUS = 8'h08;
    localparam logic [7:0] CSCC_OFS_NODES  = 8'h0c;

    // configuration register fields
    localparam int CSCC_CFG_KEYSLOT = 0;  // key_slot_startup_enable
    localparam int CSCC_CFG_HDR_SU  = 1;  // startup frame indicator in header
    localparam int CSCC_CFG_MODE_LO = 2;  // cluster sync method, 2 bits
    localparam int CSCC_CFG_CH_LO   = 4;  // attached channels a/b, 2 bits
    localparam int CSCC_CFG_ATT_LO  = 8;  // coldstart attempts, 4 bits
    localparam logic [31:0] CSCC_CFG_RESET = 32'h0000_0230;
    localparam logic [31:0] CSCC_CFG_MASK  = 32'h0000_0f3f;

    // command register bits, write-one
    localparam int CSCC_CMD_PERMIT = 0;  // permit-coldstart
    localparam int CSCC_CMD_READY  = 1;  // go to ready_state
    localparam int CSCC_CMD_RUN    = 2;  // begin startup
    localparam int CSCC_CMD_AWAKE  = 3;  // cluster wakeup completed

    // cycle and node count figures
    localparam logic [2:0] CSCC_CAS_RESOLVE_CYCLES = 3'h4;
    localparam logic [2:0] CSCC_LEADER_DONE_CYCLES = 3'h6;
    localparam logic [1:0] CSCC_MIN_DISTINCT_IDS   = 2'h2;
    localparam logic [1:0] CSCC_MIN_CS_DONE        = 2'h2;

    // cluster sync methods
    typedef enum logic [1:0] {
        CSCC_DISTRIBUTED = 2'b00,
        CSCC_LEADER      = 2'b01,
        CSCC_EXTERNAL    = 2'b10
    } cscc_mode_type;

    // protocol_state_variable encodings
    typedef enum logic [1:0] {
        CSCC_PSV_CONFIG  = 2'b00,
        CSCC_PSV_READY   = 2'b01,
        CSCC_PSV_STARTUP = 2'b10,
        CSCC_PSV_NORMAL  = 2'b11
    } cscc_psv_type;

    // controller states
    typedef enum logic [3:0] {
        CSCC_ST_CONFIG  = 4'b0000,
        CSCC_ST_READY   = 4'b0001,
        CSCC_ST_LISTEN  = 4'b0010,
        CSCC_ST_LEAD    = 4'b0011,
        CSCC_ST_INTEG   = 4'b0100,
        CSCC_ST_FOLLOW  = 4'b0101,
        CSCC_ST_NONCS   = 4'b0110,
        CSCC_ST_EXTWAIT = 4'b0111,
        CSCC_ST_NORMAL  = 4'b1000
    } cscc_state_type;

endpackage : cscc_pkg

// ===== design/cscc_startup_ctrl.sv
// Added by the designer: the register offsets and register access over APB.
module cscc_startup_ctrl
    import cscc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        cycle_start,
    input  wire logic        cas_rx,
    input  wire logic        header_rx,
    input  wire logic        listen_timeout,
    input  wire logic        startup_frame_rx,
    input  wire logic [10:0] startup_frame_id,
    input  wire logic        stable_comm,
    input  wire logic        peer_cs_done,
    input  wire logic        ext_terms_rx,
    input  wire logic        ext_src_active,
    output logic             tx_cas,
    output logic             tx_frame_enable,
    output logic             tx_startup_only,
    output logic             tx_startup_bit,
    output logic             tx_sync_bit,
    output logic      [1:0]  channel_active,
    output logic             coldstart_block_flag,
    output logic      [1:0]  protocol_state_variable
);

    ////////////////////////////////////////////////////////////////////////////
    // registers

    cscc_state_type state_ff;
    cscc_state_type nxt_state;
    logic [31:0]    cfg_ff;
    logic           block_ff;
    logic           nxt_block;
    logic           awake_ff;
    logic [3:0]     attempts_ff;
    logic [3:0]     nxt_attempts;
    logic [2:0]     cyc_ff;
    logic [2:0]     nxt_cyc;
    logic           cas_ff;
    logic           nxt_cas;
    logic           first_id_vld_ff;
    logic [10:0]    first_id_ff;
    logic [1:0]     ids_ff;
    logic [1:0]     csdone_ff;
    logic           terms_ff;
    logic           srcact_ff;

    ////////////////////////////////////////////////////////////////////////////
    // apb decode

    wire         apb_acc   = psel & penable;
    wire         apb_wr    = apb_acc & pwrite;
    wire         hit_cfg   = (paddr == CSCC_OFS_CFG);
    wire         hit_cmd   = (paddr == CSCC_OFS_CMD);
    wire         hit_stat  = (paddr == CSCC_OFS_STATUS);
    wire         hit_nodes = (paddr == CSCC_OFS_NODES);
    wire         hit_any   = hit_cfg | hit_cmd | hit_stat | hit_nodes;
    wire         cfg_wr    = apb_wr & hit_cfg & (state_ff == CSCC_ST_CONFIG);
    wire         cmd_wr    = apb_wr & hit_cmd;
    wire         cmd_permit = cmd_wr & pwdata[CSCC_CMD_PERMIT];
    wire         cmd_ready = cmd_wr & pwdata[CSCC_CMD_READY];
    wire         cmd_run   = cmd_wr & pwdata[CSCC_CMD_RUN];
    wire         cmd_awake = cmd_wr & pwdata[CSCC_CMD_AWAKE];

    // configuration fields
    wire                cfg_keyslot = cfg_ff[CSCC_CFG_KEYSLOT];
    wire                cfg_hdr_su  = cfg_ff[CSCC_CFG_HDR_SU];
    wire cscc_mode_type cfg_mode    = cscc_mode_type'(cfg_ff[CSCC_CFG_MODE_LO +: 2]);
    wire [1:0]          cfg_ch      = cfg_ff[CSCC_CFG_CH_LO +: 2];
    wire [3:0]          cfg_att     = cfg_ff[CSCC_CFG_ATT_LO +: 4];

    wire cs_node  = cfg_keyslot & cfg_hdr_su;
    wire ext_cfg  = (cfg_mode == CSCC_EXTERNAL);
    wire dist_cfg = (cfg_mode == CSCC_DISTRIBUTED);
    wire lead_cfg = (cfg_mode == CSCC_LEADER);
    wire ext_cs   = cs_node & ext_cfg;

    // startup-state test used by several outputs
    function automatic logic cscc_in_startup(input cscc_state_type s);
        cscc_in_startup = (s == CSCC_ST_LISTEN) | (s == CSCC_ST_LEAD) |
                          (s == CSCC_ST_INTEG) | (s == CSCC_ST_FOLLOW) |
                          (s == CSCC_ST_NONCS) | (s == CSCC_ST_EXTWAIT);
    endfunction : cscc_in_startup

    wire in_startup = cscc_in_startup(state_ff);

    // leading allowed only when unblocked with attempts left
    wire may_lead = cs_node & ~block_ff & (attempts_ff != 4'h0);
    wire may_follow = cs_node & ~lead_cfg;
    // second startup frame with a different id
    wire new_id = startup_frame_rx & first_id_vld_ff &
                  (startup_frame_id != first_id_ff);
    wire [1:0] ids_sat = (ids_ff == CSCC_MIN_DISTINCT_IDS) ? ids_ff : ids_ff + 2'h1;
    wire       rx_busy = cas_rx | header_rx;

    ////////////////////////////////////////////////////////////////////////////
    // startup prepare: pick path from ready or after an abort

    cscc_state_type prep_state;
    // external coldstart node goes straight to its own path
    // blocked or exhausted coldstart node integrates instead
    assign prep_state = ext_cs   ? CSCC_ST_EXTWAIT :
                        may_lead ? CSCC_ST_LISTEN  :
                        cs_node  ? CSCC_ST_INTEG   : CSCC_ST_NONCS;

    ////////////////////////////////////////////////////////////////////////////
    // state machine

    always_comb
    begin
        nxt_state    = state_ff;
        nxt_attempts = attempts_ff;
        nxt_cyc      = cyc_ff;
        nxt_cas      = 1'b0;
        case (state_ff)
            CSCC_ST_CONFIG:
            begin
                if (cmd_ready)
                begin
                    nxt_state    = CSCC_ST_READY;
                    nxt_attempts = cfg_att;
                end
            end
            CSCC_ST_READY:
            begin
                if (cmd_run & (awake_ff | cmd_awake))
                begin
                    nxt_state = prep_state;
                    nxt_cyc   = 3'h0;
                end
            end
            CSCC_ST_LISTEN:
            begin
                if (rx_busy)
                    nxt_state = may_follow ? CSCC_ST_INTEG : CSCC_ST_LISTEN;
                else if (~may_lead)
                    nxt_state = prep_state;
                else if (listen_timeout)
                begin
                    nxt_cas      = ~ext_cfg;
                    nxt_state    = CSCC_ST_LEAD;
                    nxt_attempts = attempts_ff - 4'h1;
                    nxt_cyc      = 3'h0;
                end
            end
            CSCC_ST_LEAD:
            begin
                // abandon on traffic during resolution cycles
                if (rx_busy & (cyc_ff < CSCC_CAS_RESOLVE_CYCLES))
                    nxt_state = CSCC_ST_LISTEN;
                // distributed leader done on stable peer link
                else if (dist_cfg & stable_comm & (cyc_ff >= CSCC_CAS_RESOLVE_CYCLES))
                    nxt_state = CSCC_ST_NORMAL;
                else if (cycle_start)
                begin
                    nxt_cyc = cyc_ff + 3'h1;
                    // single leader completes after six cycles
                    if (nxt_cyc == CSCC_LEADER_DONE_CYCLES)
                        nxt_state = lead_cfg ? CSCC_ST_NORMAL : prep_state;
                end
            end
            CSCC_ST_INTEG:
            begin
                if (startup_frame_rx & may_follow)
                begin
                    nxt_state = CSCC_ST_FOLLOW;
                    nxt_cyc   = 3'h0;
                end
                else if (may_lead)
                    nxt_state = CSCC_ST_LISTEN;
            end
            CSCC_ST_FOLLOW:
            begin
                // follower done on stable peer link
                if (stable_comm & (cyc_ff >= CSCC_CAS_RESOLVE_CYCLES))
                    nxt_state = CSCC_ST_NORMAL;
                else if (cycle_start & (cyc_ff != CSCC_LEADER_DONE_CYCLES))
                    nxt_cyc = cyc_ff + 3'h1;
            end
            CSCC_ST_NONCS:
            begin
                // leader and external modes: no wait for coldstart completion to integrate
                // distributed needs two finished coldstart nodes
                if ((ids_ff == CSCC_MIN_DISTINCT_IDS) & stable_comm &
                    (~dist_cfg | (csdone_ff == CSCC_MIN_CS_DONE)))
                    nxt_state = CSCC_ST_NORMAL;
            end
            CSCC_ST_EXTWAIT:
            begin
                // first cycle start after terms and source active
                if (cycle_start & terms_ff & srcact_ff)
                    nxt_state = CSCC_ST_NORMAL;
            end
            CSCC_ST_NORMAL:
            begin
                nxt_state = CSCC_ST_NORMAL;
            end
            default:
            begin
                nxt_state = CSCC_ST_CONFIG;
            end
        endcase
        if (cmd_ready & (state_ff != CSCC_ST_CONFIG))
        begin
            nxt_state    = CSCC_ST_READY;
            nxt_attempts = cfg_att;
            nxt_cas      = 1'b0;
        end
    end

    // entering ready re-arms the block, over a same-cycle permit
    // permit accepted only once ready has been reached
    // external coldstart node is never blocked
    assign nxt_block = (cmd_ready & ~ext_cs) ? 1'b1 :
                       (ext_cs | (cmd_permit & (state_ff != CSCC_ST_CONFIG))) ? 1'b0 :
                       block_ff;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff    <= CSCC_ST_CONFIG;
            block_ff    <= 1'b1;
            attempts_ff <= 4'h0;
            cyc_ff      <= 3'h0;
            cas_ff      <= 1'b0;
        end
        else
        begin
            state_ff    <= nxt_state;
            block_ff    <= nxt_block;
            attempts_ff <= nxt_attempts;
            cyc_ff      <= nxt_cyc;
            cas_ff      <= nxt_cas;
        end
    end

    // configuration and wakeup status
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_ff   <= CSCC_CFG_RESET;
            awake_ff <= 1'b0;
        end
        else
        begin
            if (cfg_wr)
                cfg_ff <= pwdata & CSCC_CFG_MASK;
            if (cmd_awake)
                awake_ff <= 1'b1;
            else if (state_ff == CSCC_ST_CONFIG)
                awake_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // integration evidence, cleared whenever startup is not running

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            first_id_vld_ff <= 1'b0;
            first_id_ff     <= 11'h000;
            ids_ff          <= 2'h0;
            csdone_ff       <= 2'h0;
            terms_ff        <= 1'b0;
            srcact_ff       <= 1'b0;
        end
        else if (!in_startup)
        begin
            first_id_vld_ff <= 1'b0;
            ids_ff          <= 2'h0;
            csdone_ff       <= 2'h0;
            terms_ff        <= 1'b0;
            srcact_ff       <= 1'b0;
        end
        else
        begin
            if (startup_frame_rx & !first_id_vld_ff)
            begin
                first_id_vld_ff <= 1'b1;
                first_id_ff     <= startup_frame_id;
                ids_ff          <= 2'h1;
            end
            else if (new_id)
                ids_ff <= ids_sat;
            if (peer_cs_done & (csdone_ff != CSCC_MIN_CS_DONE))
                csdone_ff <= csdone_ff + 2'h1;
            if (ext_terms_rx)
                terms_ff <= 1'b1;
            if (ext_src_active)
                srcact_ff <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transmit control

    assign tx_cas = cas_ff;
    // follower joins only after the resolution cycles
    // in normal operation the block flag has no say
    assign tx_frame_enable = (state_ff == CSCC_ST_NORMAL) |
                             ((state_ff == CSCC_ST_LEAD) & cs_node) |
                             ((state_ff == CSCC_ST_FOLLOW) &
                              (cyc_ff >= CSCC_CAS_RESOLVE_CYCLES));
    // startup frames only while in startup
    assign tx_startup_only = in_startup;
    // startup frames always carry the sync mark
    assign tx_startup_bit = cs_node;
    assign tx_sync_bit    = cs_node;
    // all attached channels run startup together
    assign channel_active = (in_startup | (state_ff == CSCC_ST_NORMAL)) ? cfg_ch : 2'b00;
    assign coldstart_block_flag = block_ff;
    assign protocol_state_variable =
        (state_ff == CSCC_ST_CONFIG) ? CSCC_PSV_CONFIG :
        (state_ff == CSCC_ST_READY)  ? CSCC_PSV_READY  :
        (state_ff == CSCC_ST_NORMAL) ? CSCC_PSV_NORMAL : CSCC_PSV_STARTUP;

    ////////////////////////////////////////////////////////////////////////////
    // apb read and answer

    wire [31:0] stat_word = {16'h0000, attempts_ff, 1'b0, cyc_ff,
                             awake_ff, block_ff, cs_node, 1'b0, state_ff};
    wire [31:0] node_word = {26'h0000000, csdone_ff, ids_ff, srcact_ff, terms_ff};
    wire [31:0] rd_mux = hit_cfg   ? cfg_ff    :
                         hit_stat  ? stat_word :
                         hit_nodes ? node_word : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel & !penable & !pwrite)
            prdata <= rd_mux;
    end

    assign pready  = 1'b1;
    assign pslverr = apb_acc & ~hit_any;

endmodule : cscc_startup_ctrl

// ===== verif/cscc_startup_ctrl_checker.sv
module cscc_checker
    import cscc_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        listen_timeout,
    input wire logic        tx_cas,
    input wire logic        tx_frame_enable,
    input wire logic        tx_startup_only,
    input wire logic        tx_startup_bit,
    input wire logic        tx_sync_bit,
    input wire logic [1:0]  channel_active,
    input wire logic        coldstart_block_flag,
    input wire logic [1:0]  protocol_state_variable
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // decoded apb writes and shadow of the configuration word
    logic [11:0] cfg_ff;
    wire         wr_done = psel & penable & pwrite & pready;
    wire         cmd_wr  = wr_done && paddr == CSCC_OFS_CMD;
    wire         in_cfg  = protocol_state_variable == CSCC_PSV_CONFIG;
    wire         ext_cs  = cfg_ff[1:0] == 2'h3 && cfg_ff[3:2] == CSCC_EXTERNAL;
    wire         run_on  = protocol_state_variable[1];  // startup or normal

    // configuration only changes while in config
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            cfg_ff <= CSCC_CFG_RESET[11:0];
        else if (wr_done && paddr == CSCC_OFS_CFG && in_cfg)
            cfg_ff <= pwdata[11:0] & CSCC_CFG_MASK[11:0];

    sequence s_lead_start;
        listen_timeout ##1 tx_cas;
    endsequence

    a_cas_cause: assert property (
        tx_cas |-> $past(listen_timeout) && !$past(coldstart_block_flag))
        else $error("symbol sent without timeout or while blocked");
    a_cas_one_cycle: assert property (s_lead_start |=> !tx_cas)
        else $error("symbol pulse longer than one cycle");
    a_startup_only: assert property (
        protocol_state_variable == CSCC_PSV_STARTUP |-> tx_startup_only)
        else $error("startup state without startup-only limit");
    a_normal_free: assert property (
        protocol_state_variable == CSCC_PSV_NORMAL |-> tx_frame_enable && !tx_startup_only)
        else $error("normal state still limited");
    a_sync_pair: assert property (
        presetn |-> tx_sync_bit == tx_startup_bit && tx_startup_bit == (cfg_ff[0] & cfg_ff[1]))
        else $error("startup or sync marking wrong");
    a_chan_together: assert property (
        presetn |-> channel_active == (run_on ? cfg_ff[5:4] : 2'h0))
        else $error("channels not started together");
    a_ready_blocks: assert property (
        $rose(protocol_state_variable == CSCC_PSV_READY) && !ext_cs |-> coldstart_block_flag)
        else $error("ready entered without block flag");
    a_block_holds: assert property (
        coldstart_block_flag && !in_cfg && !(cmd_wr && pwdata[CSCC_CMD_PERMIT])
        |=> coldstart_block_flag)
        else $error("block flag dropped without permit");
    a_permit_frees: assert property (
        cmd_wr && pwdata[CSCC_CMD_PERMIT] && !pwdata[CSCC_CMD_READY]
        && protocol_state_variable == CSCC_PSV_READY |=> !coldstart_block_flag)
        else $error("permit did not clear block flag");
    a_ext_unblocked: assert property (
        ext_cs && !in_cfg |-> !coldstart_block_flag)
        else $error("external coldstart node blocked");
endmodule : cscc_checker

bind cscc_startup_ctrl cscc_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .listen_timeout(listen_timeout), .tx_cas(tx_cas), .tx_frame_enable(tx_frame_enable),
    .tx_startup_only(tx_startup_only), .tx_startup_bit(tx_startup_bit),
    .tx_sync_bit(tx_sync_bit), .channel_active(channel_active),
    .coldstart_block_flag(coldstart_block_flag),
    .protocol_state_variable(protocol_state_variable));

// ===== verif/cscc_peer_model.sv
module cscc_peer_model
(
    input  wire logic   pclk,
    output logic        cycle_start,
    output logic        cas_rx,
    output logic        header_rx,
    output logic        listen_timeout,
    output logic        startup_frame_rx,
    output logic [10:0] startup_frame_id,
    output logic        stable_comm,
    output logic        peer_cs_done,
    output logic        ext_terms_rx,
    output logic        ext_src_active
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [8:0]  ev_ff = 9'h000;
    logic [10:0] id_ff = 11'h000;

    // bus events seen by the controller
    assign {cycle_start, cas_rx, header_rx, listen_timeout, startup_frame_rx,
            stable_comm, peer_cs_done, ext_terms_rx, ext_src_active} = ev_ff;
    assign startup_frame_id = id_ff;

    task automatic fire(input logic [8:0] ev, input logic [10:0] id, input int n);
        repeat (n)
        begin
            @(posedge pclk);
            ev_ff <= ev;
            id_ff <= id;
            @(posedge pclk);
            ev_ff <= 9'h000;
            id_ff <= ~id;  // stale id is not held
        end
        #1;
    endtask : fire
endmodule : cscc_peer_model

// ===== verif/tb_top.sv
module tb_top
    import cscc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [8:0] E_CYC = 9'h100, E_CAS = 9'h080, E_HDR = 9'h040, E_TMO = 9'h020;
    localparam logic [8:0] E_SUF = 9'h010, E_STB = 9'h008, E_PCD = 9'h004, E_TRM = 9'h002;
    localparam logic [8:0] E_ACT = 9'h001;
    typedef struct packed { logic [31:0] cfg; logic su; logic blk; } cscc_row_type;

    logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic        pready, pslverr, err, tx_cas, tx_frame_enable, tx_startup_only;
    logic        tx_startup_bit, tx_sync_bit, coldstart_block_flag;
    logic [1:0]  channel_active, protocol_state_variable;
    logic        cycle_start, cas_rx, header_rx, listen_timeout, startup_frame_rx;
    logic        stable_comm, peer_cs_done, ext_terms_rx, ext_src_active;
    logic [10:0] startup_frame_id;
    int          miscompares = 0, comparisons = 0;
    cscc_row_type rows [7] = '{'{32'h230, 1'h0, 1'h1}, '{32'h231, 1'h0, 1'h1},
        '{32'h232, 1'h0, 1'h1}, '{32'h233, 1'h1, 1'h1}, '{32'h237, 1'h1, 1'h1},
        '{32'h238, 1'h0, 1'h1}, '{32'h23b, 1'h1, 1'h0}};

    // 50 mhz clock
    always #10 pclk = ~pclk;

    cscc_startup_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cycle_start(cycle_start), .cas_rx(cas_rx), .header_rx(header_rx),
        .listen_timeout(listen_timeout), .startup_frame_rx(startup_frame_rx),
        .startup_frame_id(startup_frame_id), .stable_comm(stable_comm),
        .peer_cs_done(peer_cs_done), .ext_terms_rx(ext_terms_rx),
        .ext_src_active(ext_src_active), .tx_cas(tx_cas), .tx_frame_enable(tx_frame_enable),
        .tx_startup_only(tx_startup_only), .tx_startup_bit(tx_startup_bit),
        .tx_sync_bit(tx_sync_bit), .channel_active(channel_active),
        .coldstart_block_flag(coldstart_block_flag),
        .protocol_state_variable(protocol_state_variable));

    cscc_peer_model u_peer (.pclk(pclk), .cycle_start(cycle_start), .cas_rx(cas_rx),
        .header_rx(header_rx), .listen_timeout(listen_timeout),
        .startup_frame_rx(startup_frame_rx), .startup_frame_id(startup_frame_id),
        .stable_comm(stable_comm), .peer_cs_done(peer_cs_done),
        .ext_terms_rx(ext_terms_rx), .ext_src_active(ext_src_active));

    // one apb transfer, held until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'h1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        // only the watchdog ends a wait that never gets its answer
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'h1);
        q   = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        #1;
    endtask : apb

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic ps(input logic [1:0] exp);
        chk(32'(protocol_state_variable), 32'(exp));
    endtask : ps

    task automatic st(input logic [3:0] exp);
        apb(1'h0, CSCC_OFS_STATUS, 32'h0);
        chk(32'(q[3:0]), 32'(exp));
    endtask : st

    // reset, configure, go ready, optional command
    task automatic prep(input logic [31:0] cfg, input logic [31:0] cmd);
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h1, CSCC_OFS_CFG, cfg);
        apb(1'h1, CSCC_OFS_CMD, 32'h2);
        if (cmd != 32'h0)
            apb(1'h1, CSCC_OFS_CMD, cmd);
    endtask : prep

    task automatic test_done();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done

    // watchdog
    initial
    begin
        #100us;
        miscompares++;
        test_done();
    end

    // main sequence
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        #1;
        chk(32'(coldstart_block_flag), 32'h1);
        apb(1'h0, CSCC_OFS_CFG, 32'h0);
        chk(q, CSCC_CFG_RESET);
        apb(1'h0, 8'h10, 32'h0);
        chk(32'(err), 32'h1);
        apb(1'h1, CSCC_OFS_CMD, 32'h1);
        chk(32'(coldstart_block_flag), 32'h1);
        $display("reset test done");
        for (int i = 0; i < 7; i++)
        begin
            prep(rows[i].cfg, 32'h0);
            chk(32'(tx_startup_bit), 32'(rows[i].su));
            chk(32'(tx_sync_bit), 32'(rows[i].su));
            chk(32'(coldstart_block_flag), 32'(rows[i].blk));
        end
        $display("row tests done");
        prep(32'h237, 32'h1);
        chk(32'(coldstart_block_flag), 32'h0);
        apb(1'h1, CSCC_OFS_CMD, 32'hc);
        chk(32'(channel_active), 32'h3);
        chk(32'(tx_frame_enable), 32'h0);
        u_peer.fire(E_TMO, 11'h0, 1);
        chk(32'(tx_cas), 32'h1);
        u_peer.fire(E_CYC, 11'h0, 5);
        ps(CSCC_PSV_STARTUP);
        u_peer.fire(E_CYC, 11'h0, 1);
        ps(CSCC_PSV_NORMAL);
        $display("single leader test done");
        prep(32'h233, 32'h1);
        apb(1'h1, CSCC_OFS_CMD, 32'hc);
        u_peer.fire(E_TMO, 11'h0, 1);
        u_peer.fire(E_CYC, 11'h0, 1);
        u_peer.fire(E_CAS, 11'h0, 1);
        st(4'h2);
        u_peer.fire(E_TMO, 11'h0, 1);
        u_peer.fire(E_HDR, 11'h0, 1);
        st(4'h4);
        chk(32'(q[15:12]), 32'h0);
        u_peer.fire(E_TMO, 11'h0, 1);
        chk(32'(tx_cas), 32'h0);
        prep(32'h233, 32'h1);
        apb(1'h1, CSCC_OFS_CMD, 32'hc);
        u_peer.fire(E_TMO, 11'h0, 1);
        u_peer.fire(E_CYC, 11'h0, 4);
        u_peer.fire(E_STB, 11'h0, 1);
        ps(CSCC_PSV_NORMAL);
        $display("distributed leader test done");
        prep(32'h233, 32'h0);
        apb(1'h1, CSCC_OFS_CMD, 32'hc);
        u_peer.fire(E_TMO, 11'h0, 1);
        chk(32'(tx_cas), 32'h0);
        u_peer.fire(E_SUF, 11'h7, 1);
        st(4'h5);
        u_peer.fire(E_CYC, 11'h0, 3);
        chk(32'(tx_frame_enable), 32'h0);
        u_peer.fire(E_CYC, 11'h0, 1);
        chk(32'(tx_frame_enable), 32'h1);
        u_peer.fire(E_STB, 11'h0, 1);
        ps(CSCC_PSV_NORMAL);
        chk(32'(coldstart_block_flag), 32'h1);
        $display("blocked follower test done");
        prep(32'h230, 32'h0);
        apb(1'h1, CSCC_OFS_CMD, 32'h4);
        ps(CSCC_PSV_READY);
        apb(1'h1, CSCC_OFS_CMD, 32'hc);
        u_peer.fire(E_SUF, 11'h5, 2);
        u_peer.fire(E_STB, 11'h0, 1);
        ps(CSCC_PSV_STARTUP);
        u_peer.fire(E_SUF, 11'h9, 1);
        apb(1'h0, CSCC_OFS_NODES, 32'h0);
        chk(32'(q[3:2]), 32'h2);
        st(4'h6);
        u_peer.fire(E_PCD | E_STB, 11'h0, 1);
        ps(CSCC_PSV_STARTUP);
        u_peer.fire(E_PCD, 11'h0, 1);
        u_peer.fire(E_STB, 11'h0, 1);
        ps(CSCC_PSV_NORMAL);
        $display("non-coldstart test done");
        prep(32'h23b, 32'h0);
        apb(1'h1, CSCC_OFS_CMD, 32'hc);
        u_peer.fire(E_CYC, 11'h0, 1);
        ps(CSCC_PSV_STARTUP);
        u_peer.fire(E_TRM, 11'h0, 1);
        u_peer.fire(E_ACT, 11'h0, 1);
        u_peer.fire(E_CYC, 11'h0, 1);
        ps(CSCC_PSV_NORMAL);
        chk(32'(coldstart_block_flag), 32'h0);
        $display("external test done");
        test_done();
    end
endmodule : tb_top
